// ===== verilog/bst_tap.sv
// Boundary-scan test access port: controller, instruction register, data
// registers and the pad control that applies the active instruction.
// Assumes a board tester drives the scan pins on tck_i, and that core_* come
// from system logic on sys_clk_i while pad_* face the pads.
`timescale 1ns/10ps
`include "bst_cfg.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int unsigned          NOUT     = `BST_NOUT,
  parameter int unsigned          NIN      = `BST_NIN,
  // Identification value is arbitrary; bit 0 must stay one.
  parameter logic [`BST_ID_W-1:0] ID_VALUE = 32'h1000_0001
)(
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire logic            tck_i,
  input  wire logic            tms_i,
  input  wire logic            tdi_i,
  input  wire logic            trst_n_i,
  input  wire logic            dbg_mode_i,
  input  wire logic [NOUT-1:0] core_out_i,
  input  wire logic [NOUT-1:0] core_oe_i,
  input  wire logic [NIN-1:0]  pad_in_i,
  output logic                 tdo_o,
  output logic                 tdo_oe_o,
  output logic [NOUT-1:0]      pad_out_o,
  output logic [NOUT-1:0]      pad_oe_o,
  output logic                 func_rst_o
);
  localparam int unsigned BSR_W = NIN + 2 * NOUT;
  localparam int unsigned XW    = 3 + 2 * NOUT;
  if (NOUT < 1 || NIN < 1)
  begin : g_bad
    $error("bst_tap needs at least one output and one input pin.");
  end
  logic                    tap_rst;
  bst_state_t              st_q;
  bst_state_t              st_d;
  logic [`BST_IR_W-1:0]    ir_sh_q;
  logic [`BST_IR_W-1:0]    ir_q;
  logic                    sel_bsr;
  logic                    sel_id;
  bst_mode_t               mode;
  logic                    bypass_q;
  logic [`BST_ID_W-1:0]    id_sh_q;
  logic [BSR_W-1:0]        bsr_sh_q;
  logic [BSR_W-1:0]        bsr_upd_q;
  logic                    tdo_q;
  logic                    tdo_oe_q;
  logic [BSR_W-1:0]        obs_raw;
  logic [BSR_W-1:0]        obs_s1;
  logic [BSR_W-1:0]        obs_s2;
  logic [BSR_W-1:0]        obs_s3;
  logic [BSR_W-1:0]        obs_st_q;
  logic [XW-1:0]           x_s1;
  logic [XW-1:0]           x_s2;
  logic [XW-1:0]           x_s3;
  logic [XW-1:0]           x_q;
  bst_mode_t               mode_s;
  logic [NOUT-1:0]         upd_out;
  logic [NOUT-1:0]         upd_oe;
  logic [NOUT-1:0]         pad_out_q;
  logic [NOUT-1:0]         pad_oe_q;
  logic                    func_rst_q;

  // The compliance pin acts as a reset so debug use cannot disturb scan state.
  assign tap_rst = ~trst_n_i | dbg_mode_i;

  always_comb
  begin
    case (st_q)
      ST_TLR:   st_d = tms_i ? ST_TLR : ST_RTI;
      ST_RTI:   st_d = tms_i ? ST_SELDR : ST_RTI;
      ST_SELDR: st_d = tms_i ? ST_SELIR : ST_CDR;
      ST_CDR:   st_d = tms_i ? ST_E1DR : ST_SDR;
      ST_SDR:   st_d = tms_i ? ST_E1DR : ST_SDR;
      ST_E1DR:  st_d = tms_i ? ST_UDR : ST_PDR;
      ST_PDR:   st_d = tms_i ? ST_E2DR : ST_PDR;
      ST_E2DR:  st_d = tms_i ? ST_UDR : ST_SDR;
      ST_UDR:   st_d = tms_i ? ST_SELDR : ST_RTI;
      ST_SELIR: st_d = tms_i ? ST_TLR : ST_CIR;
      ST_CIR:   st_d = tms_i ? ST_E1IR : ST_SIR;
      ST_SIR:   st_d = tms_i ? ST_E1IR : ST_SIR;
      ST_E1IR:  st_d = tms_i ? ST_UIR : ST_PIR;
      ST_PIR:   st_d = tms_i ? ST_E2IR : ST_PIR;
      ST_E2IR:  st_d = tms_i ? ST_UIR : ST_SIR;
      ST_UIR:   st_d = tms_i ? ST_SELDR : ST_RTI;
      default:  st_d = ST_TLR;
    endcase
  end
  always_ff @(posedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
      st_q <= ST_TLR;
    else
      st_q <= st_d;
  end
  always_comb
  begin
    sel_bsr = 1'b0;
    sel_id  = 1'b0;
    mode    = '0;
    case (ir_q)
      `BST_IR_EXTEST:
      begin
        sel_bsr       = 1'b1;
        mode.drive_bs = 1'b1;
        mode.frst     = 1'b1;
      end
      `BST_IR_IDCODE: sel_id = 1'b1;
      `BST_IR_SAMPLE: sel_bsr = 1'b1;
      `BST_IR_HIGHZ:
      begin
        mode.hiz  = 1'b1;
        mode.frst = 1'b1;
      end
      `BST_IR_CLAMP:
      begin
        mode.drive_bs = 1'b1;
        mode.frst     = 1'b1;
      end
      default:        sel_id = 1'b0;
    endcase
  end

  // Pin states cross from their own domains; a bit counts once two stages
  // agree. Capture needs a few test clocks of settling before Capture-DR.
  assign obs_raw = {core_oe_i, core_out_i, pad_in_i};
  for (genvar i = 0; i < BSR_W; i++)
  begin : g_obs
    always_ff @(posedge tck_i or posedge tap_rst)
    begin
      if (tap_rst)
      begin
        obs_s1[i]   <= 1'b0;
        obs_s2[i]   <= 1'b0;
        obs_s3[i]   <= 1'b0;
        obs_st_q[i] <= 1'b0;
      end
      else
      begin
        obs_s1[i] <= obs_raw[i];
        obs_s2[i] <= obs_s1[i];
        obs_s3[i] <= obs_s2[i];
        if (obs_s2[i] == obs_s3[i])
          obs_st_q[i] <= obs_s3[i];
      end
    end
  end

  always_ff @(posedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
      ir_sh_q <= `BST_IR_IDCODE;
    else if (st_q == ST_TLR || st_q == ST_CIR)
      ir_sh_q <= `BST_IR_IDCODE;
    else if (st_q == ST_SIR)
      ir_sh_q <= {tdi_i, ir_sh_q[`BST_IR_W-1:1]};
  end
  always_ff @(posedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      bypass_q <= 1'b0;
      id_sh_q  <= '0;
      bsr_sh_q <= '0;
    end
    else if (st_q == ST_CDR)
    begin
      bypass_q <= 1'b0;
      id_sh_q  <= ID_VALUE;
      if (sel_bsr)
        bsr_sh_q <= obs_st_q;
    end
    else if (st_q == ST_SDR)
    begin
      bypass_q <= tdi_i;
      id_sh_q  <= {tdi_i, id_sh_q[`BST_ID_W-1:1]};
      if (sel_bsr)
        bsr_sh_q <= {tdi_i, bsr_sh_q[BSR_W-1:1]};
    end
  end
  always_ff @(negedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
      ir_q <= `BST_IR_IDCODE;
    else if (st_q == ST_TLR)
      ir_q <= `BST_IR_IDCODE;
    else if (st_q == ST_UIR)
      ir_q <= ir_sh_q;
  end
  always_ff @(negedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
      bsr_upd_q <= '0;
    else if (st_q == ST_UDR && sel_bsr)
      bsr_upd_q <= bsr_sh_q;
  end

  always_ff @(negedge tck_i or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_oe_q <= (st_q == ST_SIR) || (st_q == ST_SDR);
      tdo_q    <= (st_q == ST_SIR) ? ir_sh_q[0] : (sel_bsr ? bsr_sh_q[0] : (sel_id ? id_sh_q[0] : bypass_q));
    end
  end

  // Mode and update cells are steady while a test runs, so a word crossing
  // that waits for two agreeing stages is enough for them.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      x_s1 <= '0;
      x_s2 <= '0;
      x_s3 <= '0;
      x_q  <= '0;
    end
    else
    begin
      x_s1 <= {mode, bsr_upd_q[BSR_W-1:NIN]};
      x_s2 <= x_s1;
      x_s3 <= x_s2;
      if (x_s2 == x_s3)
        x_q <= x_s3;
    end
  end

  assign {mode_s, upd_oe, upd_out} = x_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pad_out_q  <= '0;
      pad_oe_q   <= '0;
      func_rst_q <= 1'b0;
    end
    else
    begin
      func_rst_q <= mode_s.frst;
      if (mode_s.hiz)
      begin
        pad_out_q <= '0;
        pad_oe_q  <= '0;
      end
      else if (mode_s.drive_bs)
      begin
        pad_out_q <= upd_out;
        pad_oe_q  <= upd_oe;
      end
      else
      begin
        pad_out_q <= core_out_i;
        pad_oe_q  <= core_oe_i;
      end
    end
  end

  assign tdo_o      = tdo_q;
  assign tdo_oe_o   = tdo_oe_q;
  assign pad_out_o  = pad_out_q;
  assign pad_oe_o   = pad_oe_q;
  assign func_rst_o = func_rst_q;

  property p_tlr_five;
    @(posedge tck_i) disable iff (tap_rst)
      tms_i [*5] |=> st_q == ST_TLR;
  endproperty
  a_tlr_five: assert property (p_tlr_five) else $error("No reset state after five high TMS.");
  property p_cap_ir;
    @(posedge tck_i) disable iff (tap_rst)
      st_q == ST_CIR |=> ir_sh_q == `BST_IR_IDCODE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR did not load the id code.");
  property p_cap_bypass;
    @(posedge tck_i) disable iff (tap_rst)
      (st_q == ST_CDR) |=> !bypass_q;
  endproperty
  a_cap_bypass: assert property (p_cap_bypass) else $error("Bypass cell did not capture zero.");
  property p_bypass_path;
    @(posedge tck_i) disable iff (tap_rst)
      (st_q == ST_SDR && !sel_bsr && !sel_id) |=> bypass_q == $past(tdi_i) ##1 1'b1;
  endproperty
  a_bypass_path: assert property (p_bypass_path) else $error("Bypass cell did not take TDI.");
  property p_tdo_oe;
    @(posedge tck_i) disable iff (tap_rst)
      tdo_oe_q == ((st_q == ST_SIR) || (st_q == ST_SDR));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("TDO enable outside shift states.");
  property p_tdo_id;
    @(posedge tck_i) disable iff (tap_rst)
      (st_q == ST_SDR && sel_id) |-> tdo_q == id_sh_q[0];
  endproperty
  a_tdo_id: assert property (p_tdo_id) else $error("TDO not set on the falling edge.");
  property p_ir_update;
    @(negedge tck_i) disable iff (tap_rst)
      st_q == ST_UIR |=> ir_q == $past(ir_sh_q);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction not updated in Update-IR.");
  property p_debug_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (dbg_mode_i || !trst_n_i) |-> (st_q == ST_TLR && !tdo_oe_q && ir_q == `BST_IR_IDCODE);
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("Scan logic not held in reset.");
  property p_hiz;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode_s.hiz |=> pad_oe_o == '0 && func_rst_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("Pins driven under high impedance mode.");
endmodule

// ===== verilog/bst_cfg.svh
// Constants of the boundary-scan test port: instruction codes and sizes.
// Definitions only; included by the port module by its bare name.
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
`define BST_IR_W      3
`define BST_IR_EXTEST 3'h0
`define BST_IR_IDCODE 3'h1
`define BST_IR_SAMPLE 3'h4
`define BST_IR_HIGHZ  3'h5
`define BST_IR_CLAMP  3'h6
`define BST_IR_BYPASS 3'h7
`define BST_ID_W      32
`define BST_NOUT      4
`define BST_NIN       4
`endif

// ===== verilog/bst_pkg.sv
// Types of the boundary-scan test port: controller states and pin mode.
// Assumes nothing beyond the compiler; holds no logic.
package bst_pkg;
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CDR   = 16'h0008,
    ST_SDR   = 16'h0010,
    ST_E1DR  = 16'h0020,
    ST_PDR   = 16'h0040,
    ST_E2DR  = 16'h0080,
    ST_UDR   = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CIR   = 16'h0400,
    ST_SIR   = 16'h0800,
    ST_E1IR  = 16'h1000,
    ST_PIR   = 16'h2000,
    ST_E2IR  = 16'h4000,
    ST_UIR   = 16'h8000
  } bst_state_t;

  typedef struct packed {
    logic drive_bs;
    logic hiz;
    logic frst;
  } bst_mode_t;
endpackage

// ===== tb/bst_tester_model.sv
// Board tester model: makes the test clock and runs instruction and data scans.
// Assumes the port samples on the rising test clock and drives its output on the falling one.
`timescale 1ns/10ps
module bst_tester_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic smp_tdo;
  logic smp_oe;

  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One test clock period; the clock stands low between frames. A released
  // output has no pull on this board, so the model reads the inverse of its
  // last value and a bit taken outside a shift state cannot pass by chance.
  task automatic step(input logic t, input logic d);
    tms_o = t;
    tdi_o = d;
    #15;
    smp_tdo = tdo_oe_i ? tdo_i : ~tdo_i;
    smp_oe  = tdo_oe_i;
    tck_o   = 1'b1;
    #15;
    tck_o = 1'b0;
  endtask

  // Full scan from and back to Run-Test-Idle, shifting n bits LSB first.
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output int n_oe);
    dout = '0;
    n_oe = 0;
    step(1'b1, 1'b1);
    if (is_ir)
      step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      dout[i] = smp_tdo;
      if (smp_oe === 1'b1)
        n_oe++;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    // Released select and data lines go back to their pull-up level.
    tms_o = 1'b1;
    tdi_o = 1'b1;
    #15;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the boundary-scan port: scan paths, modes and pads.
// Assumes bst_tester_model drives the test pins; core and pad inputs come from here.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam logic [31:0] ID = 32'h0A5C_3E1B; // Arbitrary value, bit 0 set.
  int          n_errors = 0;
  int          compares = 0;
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        trst_n   = 1'b0;
  logic        dbg_mode = 1'b0;
  logic [3:0]  core_out = 4'h5;
  logic [3:0]  core_oe  = 4'hC;
  logic [3:0]  pad_in   = 4'hA;
  logic        tck, tms, tdi, tdo, tdo_oe, func_rst;
  logic [3:0]  pad_out, pad_oe;
  logic [31:0] d;
  int          n_oe;

  always #20 sys_clk = ~sys_clk;

  bst_tap #(.NOUT(4), .NIN(4), .ID_VALUE(ID)) u_bst_tap (
    .sys_clk_i(sys_clk), .rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .dbg_mode_i(dbg_mode), .core_out_i(core_out),
    .core_oe_i(core_oe), .pad_in_i(pad_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .func_rst_o(func_rst));

  bst_tester_model u_bst_tester_model (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // The mode word needs several system edges to cross; ten leaves margin.
  task automatic sys_wait();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_ir(input logic [2:0] c);
    u_bst_tester_model.scan(1'b1, 3, {29'h0, c}, d, n_oe);
  endtask

  task automatic id_scan();
    u_bst_tester_model.scan(1'b0, 32, 32'h0, d, n_oe);
    `CHK("id_value", ID, d)
    `CHK("id_oe", 32, n_oe)
  endtask

  task automatic t_trst();
    set_ir(3'h7);
    @(posedge sys_clk);
    #1;
    trst_n = 1'b0;
    #5;
    trst_n = 1'b1;
    u_bst_tester_model.step(1'b0, 1'b1);
    id_scan();
    u_bst_tester_model.scan(1'b1, 3, 32'h7, d, n_oe);
    `CHK("ir_capture", 3'h1, d[2:0])
    `CHK("ir_oe", 3, n_oe)
    `CHK("idle_oe", 1'b0, tdo_oe)
    set_ir(3'h1);
    id_scan();
    $display("t_trst done");
  endtask

  task automatic t_tms5();
    set_ir(3'h7);
    repeat (5) u_bst_tester_model.step(1'b1, 1'b1);
    u_bst_tester_model.step(1'b0, 1'b1);
    id_scan();
    $display("t_tms5 done");
  endtask

  task automatic t_bypass();
    logic [2:0] codes [5] = '{3'h7, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [2:0] c;
    for (int k = 0; k < 5; k++)
    begin
      c = codes[k];
      set_ir(c);
      u_bst_tester_model.scan(1'b0, 4, 32'hB, d, n_oe);
      `CHK("bypass_path", 4'h6, d[3:0])
      sys_wait();
      `CHK("pad_oe", (c == 3'h5 || c == 3'h6) ? 4'h0 : core_oe, pad_oe)
      `CHK("func_rst", (c == 3'h5 || c == 3'h6), func_rst)
      `CHK("pad_out", (c == 3'h5 || c == 3'h6) ? 4'h0 : core_out, pad_out)
    end
    $display("t_bypass done");
  endtask

  task automatic t_preload();
    logic [2:0] c;
    set_ir(3'h4);
    u_bst_tester_model.scan(1'b0, 12, 32'h930, d, n_oe);
    `CHK("sample_cap", 12'hC5A, d[11:0])
    sys_wait();
    `CHK("sample_out", core_out, pad_out)
    `CHK("sample_frst", 1'b0, func_rst)
    for (int k = 0; k < 2; k++)
    begin
      c = k ? 3'h6 : 3'h0;
      set_ir(c);
      if (k == 0)
      begin
        u_bst_tester_model.scan(1'b0, 12, 32'h930, d, n_oe);
        `CHK("extest_cap", 12'hC5A, d[11:0])
      end
      sys_wait();
      `CHK("held_out", 4'h3, pad_out)
      `CHK("held_oe", 4'h9, pad_oe)
      `CHK("held_frst", 1'b1, func_rst)
    end
    set_ir(3'h7);
    $display("t_preload done");
  endtask

  task automatic t_debug();
    @(posedge sys_clk);
    #1;
    dbg_mode = 1'b1;
    u_bst_tester_model.scan(1'b1, 3, 32'h7, d, n_oe);
    `CHK("debug_oe", 0, n_oe)
    @(posedge sys_clk);
    #1;
    dbg_mode = 1'b0;
    u_bst_tester_model.step(1'b0, 1'b1);
    id_scan();
    $display("t_debug done");
  endtask

  task automatic stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("rst_pad_oe", 4'h0, pad_oe)
    rst    = 1'b0;
    trst_n = 1'b1;
    u_bst_tester_model.step(1'b0, 1'b1);
    t_trst();
    t_tms5();
    t_bypass();
    t_preload();
    t_debug();
    stop_test();
  end

  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule
